/* File: inc/dmr_pkg.sv */
// Functional notes
// - four mode registers, written only by MRS
// - write every register before normal use
// - every MRS drives all address fields
// - consecutive MRS spaced by at least tMRD
// - only MRS/NOP/DES until tMOD elapses
// - reprogram only when idle, CKE high
// - all-low command with BA zero writes MR0
// - MR0 write drives BA2, A13-A15 zero
// - WR code at least the minimum
// - A0-A1 pick BC4, BL8 or on-the-fly
// - fixed BC4 pulls write timing two clocks
// - keep test mode bit A7 at zero
package dmr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TMRD_CK       = 4;
  localparam int TMOD_NS       = 15;
  localparam int TMOD_MIN_CK   = 12;
  localparam int TMOD_NS_CK    = (TMOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMOD_CK       = (TMOD_NS_CK > TMOD_MIN_CK) ? TMOD_NS_CK : TMOD_MIN_CK;
  localparam int TIMER_W       = 4;
  localparam logic [TIMER_W-1:0] TMRD_LOAD = TIMER_W'(TMRD_CK - 1);
  localparam logic [TIMER_W-1:0] TMOD_LOAD = TIMER_W'(TMOD_CK - 1);

  // ==========================================================
  // register map
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_MR0  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_MRX  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STAT = 4'hc;

  localparam int CTRL_GO     = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_CKE    = 4;
  localparam int CTRL_RST    = 5;

  localparam int STAT_BUSY    = 0;
  localparam int STAT_MRD     = 1;
  localparam int STAT_MOD     = 2;
  localparam int STAT_REFUSED = 3;
  localparam int STAT_INIT    = 4;
  localparam int STAT_BC4FIX  = 5;
  localparam int STAT_WRIT_LO = 8;

  // ==========================================================
  // mode register 0 fields
  localparam int MR_W       = 16;
  localparam int MR_NUM     = 4;
  localparam int MR0_BL_LO  = 0;
  localparam int MR0_BT     = 3;
  localparam int MR0_TM     = 7;
  localparam int MR0_DLL    = 8;
  localparam int MR0_WR_LO  = 9;
  localparam int MR0_RFU_LO = 13;
  localparam logic [1:0] SEL_MR0     = 2'h0;
  localparam logic [1:0] BL_FIX4     = 2'h2;
  localparam logic [2:0] WR_MIN_CODE = 3'h1;
  localparam logic [2:0] WR_MAX_CODE = 3'h0;

  // ==========================================================
  // commands {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hf;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MRS  = 3'h2,
    ST_WAIT = 3'h4
  } dmr_state_t;

endpackage

/* File: verif/dmr_dev_model.sv */
`timescale 1ns/100ps
module dmr_dev_model (
  input  wire logic        clk_sys,
  input  wire logic        resetN,
  input  wire logic        cke,
  input  wire logic        csN,
  input  wire logic        rasN,
  input  wire logic        casN,
  input  wire logic        weN,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr,
  output logic [3:0][15:0] modeReg,
  output logic [3:0]       writtenMask,
  output logic [15:0]      lastAddr,
  output logic [7:0]       errCount
);
  logic [3:0] cmd;
  logic [7:0] sinceMrs;
  logic       isMrs;
  assign cmd = {csN, rasN, casN, weN};
  assign isMrs = cke && cmd == dmr_pkg::CMD_MRS;
  // ==========================================================
  // mode registers; no array is kept, so mrs never disturbs data
  always_ff @(posedge clk_sys) begin
    if (!resetN) begin
      modeReg <= 'x;
      writtenMask <= '0;
      lastAddr <= '0;
    end else if (isMrs) begin
      modeReg[ba[1:0]] <= addr;
      writtenMask[ba[1:0]] <= 1'b1;
      lastAddr <= addr;
    end else if (modeReg[0][8] === 1'b1) begin
      modeReg[0][8] <= 1'b0;
    end
  end
  // ==========================================================
  // timing watch; saturates so idle time never wraps
  always_ff @(posedge clk_sys) begin
    if (!resetN) begin
      sinceMrs <= 8'hff;
      errCount <= '0;
    end else if (cke) begin
      if (isMrs) begin
        sinceMrs <= 8'h0;
        if (sinceMrs < 8'(dmr_pkg::TMRD_CK - 1) || ba[2] || addr[15:13] != 3'h0) begin
          errCount <= errCount + 8'h1;
        end
      end else begin
        if (sinceMrs != 8'hff) begin
          sinceMrs <= sinceMrs + 8'h1;
        end
        if (!cmd[3] && cmd != dmr_pkg::CMD_NOP && sinceMrs < 8'(dmr_pkg::TMOD_CK - 1)) begin
          errCount <= errCount + 8'h1;
        end
      end
    end
  end
endmodule

/* File: verif/tb_dmr_mode_ctrl.sv */
`timescale 1ns/100ps
module tb_dmr_mode_ctrl;
  // ==========================================================
  // stimulus and observation
  logic             clk_sys = 1'b0;
  logic             rst_n = 1'b0;
  logic [3:0]       regAddr = 4'h0;
  logic [31:0]      regWdata = 32'h0;
  logic             regWr = 1'b0;
  logic             regRd = 1'b0;
  logic             devIdle = 1'b1;
  logic             userReq = 1'b0;
  logic [3:0]       userCmd = 4'hf;
  logic [2:0]       userBa = 3'h0;
  logic [15:0]      userAddr = 16'h0;
  logic [31:0]      regRdata;
  logic             userAck;
  logic             ddrResetN;
  logic             ddrCke;
  logic             ddrCsN;
  logic             ddrRasN;
  logic             ddrCasN;
  logic             ddrWeN;
  logic [2:0]       ddrBa;
  logic [15:0]      ddrAddr;
  logic [3:0][15:0] modeReg;
  logic [3:0]       writtenMask;
  logic [15:0]      lastAddr;
  logic [7:0]       errCount;
  int               nFail = 0;
  int               checkCount = 0;
  int               cycles = 0;
  int               n;

  always #20 clk_sys = ~clk_sys;

  dmr_mode_ctrl u_dmr_mode_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .devIdle(devIdle),
    .userReq(userReq), .userCmd(userCmd), .userBa(userBa), .userAddr(userAddr),
    .userAck(userAck), .ddrResetN(ddrResetN), .ddrCke(ddrCke), .ddrCsN(ddrCsN),
    .ddrRasN(ddrRasN), .ddrCasN(ddrCasN), .ddrWeN(ddrWeN), .ddrBa(ddrBa),
    .ddrAddr(ddrAddr));

  dmr_dev_model u_dmr_dev_model (
    .clk_sys(clk_sys), .resetN(ddrResetN), .cke(ddrCke), .csN(ddrCsN),
    .rasN(ddrRasN), .casN(ddrCasN), .weN(ddrWeN), .ba(ddrBa), .addr(ddrAddr),
    .modeReg(modeReg), .writtenMask(writtenMask), .lastAddr(lastAddr),
    .errCount(errCount));

  // ==========================================================
  // access tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic wait_idle;
    logic [31:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(dmr_pkg::OFF_STAT, d);
      if (d[dmr_pkg::STAT_BUSY] === 1'b0) break;
    end
  endtask

  // the command shows on the pins only in the ack cycle
  task automatic user_cmd(input logic [3:0] c, input logic [15:0] a,
                          input logic [3:0] expCmd, output int waited);
    @(posedge clk_sys);
    userReq <= 1'b1;
    userCmd <= c;
    userAddr <= a;
    for (waited = 1; waited < 100; waited++) begin
      @(posedge clk_sys);
      #1;
      if (userAck === 1'b1) break;
    end
    chk("user ack", 32'h1, {31'h0, userAck});
    chk("user pins", {28'h0, expCmd}, {28'h0, ddrCsN, ddrRasN, ddrCasN, ddrWeN});
    if (expCmd == c) chk("user addr", {16'h0, a}, {16'h0, ddrAddr});
    @(posedge clk_sys);
    userReq <= 1'b0;
  endtask

  task automatic summarize;
    if (nFail == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      nFail++;
      summarize;
    end
  end

  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    chk("reset pins", 32'hf, {28'h0, ddrCsN, ddrRasN, ddrCasN, ddrWeN});
    chk("reset device pin", 32'h0, {31'h0, ddrResetN});
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("stat after reset", dmr_pkg::OFF_STAT, 32'h0);
    wr(dmr_pkg::OFF_CTRL, 32'h1);
    rchk("go with cke low", dmr_pkg::OFF_STAT, 32'h8);
    wr(dmr_pkg::OFF_STAT, 32'h8);
    wr(dmr_pkg::OFF_CTRL, 32'h30);
    // cke pin lags the control register by one clock
    @(posedge clk_sys);
    #1;
    chk("cke pin", 32'h1, {31'h0, ddrCke});
    @(posedge clk_sys);
    devIdle <= 1'b0;
    wr(dmr_pkg::OFF_CTRL, 32'h31);
    rchk("go while busy banks", dmr_pkg::OFF_STAT, 32'h8);
    wr(dmr_pkg::OFF_STAT, 32'h8);
    devIdle <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      wr(dmr_pkg::OFF_MRX, 32'he000 | 32'(i * 17));
      wr(dmr_pkg::OFF_CTRL, 32'h31 | 32'(i << 1));
      if (i == 2) begin
        rchk("timers running", dmr_pkg::OFF_STAT, 32'h607);
      end
      if (i == 1) begin
        wr(dmr_pkg::OFF_CTRL, 32'h33);
        wait_idle;
        rchk("second go refused", dmr_pkg::OFF_STAT, 32'h208);
        wr(dmr_pkg::OFF_STAT, 32'h8);
      end
      wait_idle;
      chk("mode register", 32'(i * 17), {16'h0, modeReg[i]});
    end
    wr(dmr_pkg::OFF_MR0, 32'he1a2);
    rchk("mr0 shadow", dmr_pkg::OFF_MR0, 32'h122);
    wr(dmr_pkg::OFF_CTRL, 32'h31);
    user_cmd(4'h3, 16'h0123, 4'h3, n);
    chk("tmod hold", 32'h1, {31'h0, n >= dmr_pkg::TMOD_CK});
    chk("mr0 at pins", 32'h122, {16'h0, lastAddr});
    chk("mr0 in device", 32'h22, {16'h0, modeReg[0]});
    chk("burst type bit", 32'h0, {31'h0, modeReg[0][dmr_pkg::MR0_BT]});
    chk("cas field", 32'h4, {28'h0, modeReg[0][6:4], modeReg[0][2]});
    chk("pd exit bit", 32'h0, {31'h0, modeReg[0][12]});
    rchk("dll bit cleared", dmr_pkg::OFF_MR0, 32'h22);
    rchk("stat all written", dmr_pkg::OFF_STAT, 32'hf30);
    rchk("ctrl readback", dmr_pkg::OFF_CTRL, 32'h30);
    user_cmd(4'h0, 16'h0, dmr_pkg::CMD_NOP, n);
    rchk("user mrs refused", dmr_pkg::OFF_STAT, 32'hf38);
    rchk("unmapped", 4'h2, 32'h0);
    chk("device faults", 32'h0, {24'h0, errCount});
    chk("written mask", 32'hf, {28'h0, writtenMask});
    summarize;
  end
endmodule

/* File: verilog/dmr_mode_ctrl.sv */
`timescale 1ns/100ps
module dmr_mode_ctrl (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire logic [dmr_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [31:0]                   regWdata,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [31:0]                   regRdata,
  input  wire logic                          devIdle,
  input  wire logic                          userReq,
  input  wire logic [3:0]                    userCmd,
  input  wire logic [2:0]                    userBa,
  input  wire logic [dmr_pkg::MR_W-1:0]      userAddr,
  output logic                               userAck,
  output logic                               ddrResetN,
  output logic                               ddrCke,
  output logic                               ddrCsN,
  output logic                               ddrRasN,
  output logic                               ddrCasN,
  output logic                               ddrWeN,
  output logic      [2:0]                    ddrBa,
  output logic      [dmr_pkg::MR_W-1:0]      ddrAddr
);

  dmr_pkg::dmr_state_t               stateReg;
  dmr_pkg::dmr_state_t               stateNext;
  logic [1:0]                        selReg;
  logic                              ckeReg;
  logic                              rstRelReg;
  logic [dmr_pkg::MR_W-1:0]          mr0Reg;
  logic [dmr_pkg::MR_W-1:0]          mrxReg;
  logic [dmr_pkg::MR_NUM-1:0]        writtenReg;
  logic                              pendReg;
  logic                              refusedReg;
  logic                              userAckReg;
  logic                              mrdRun;
  logic                              modRun;
  logic                              allInit;
  logic                              wrCtrl;
  logic                              wrMr0;
  logic                              wrStat;
  logic                              goReq;
  logic                              goOk;
  logic                              wrCodeOk;
  logic                              issue;
  logic                              userFire;
  logic                              userBad;
  logic                              canIssue;
  logic [2:0]                        wrCode;
  logic [dmr_pkg::MR_W-1:0]          mrsAddr;
  logic [31:0]                       rdMux;

  // ==========================================================
  // decode
  always_comb begin
    wrCtrl   = regWr && (regAddr == dmr_pkg::OFF_CTRL);
    wrMr0    = regWr && (regAddr == dmr_pkg::OFF_MR0);
    wrStat   = regWr && (regAddr == dmr_pkg::OFF_STAT);
    goReq    = wrCtrl && regWdata[dmr_pkg::CTRL_GO];
    allInit  = &writtenReg;
    wrCode   = mr0Reg[dmr_pkg::MR0_WR_LO +: 3];
    // code zero is the longest recovery, so it always passes
    wrCodeOk = (wrCode == dmr_pkg::WR_MAX_CODE) || (wrCode >= dmr_pkg::WR_MIN_CODE);
    goOk     = !pendReg && (stateReg == dmr_pkg::ST_IDLE) && devIdle && ckeReg
               && ((regWdata[dmr_pkg::CTRL_SEL_LO +: 2] != dmr_pkg::SEL_MR0) || wrCodeOk);
    canIssue = (stateReg != dmr_pkg::ST_MRS) && !mrdRun;
    issue    = pendReg && canIssue && devIdle && ckeReg;
    userBad  = (userCmd == dmr_pkg::CMD_MRS);
    userFire = userReq && !userAckReg && !userBad && (stateReg == dmr_pkg::ST_IDLE)
               && !modRun && !pendReg && allInit;
  end

  // ==========================================================
  // control register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      selReg    <= 2'h0;
      ckeReg    <= 1'b0;
      rstRelReg <= 1'b0;
    end else if (wrCtrl) begin
      ckeReg    <= regWdata[dmr_pkg::CTRL_CKE];
      rstRelReg <= regWdata[dmr_pkg::CTRL_RST];
      if (goReq && goOk) begin
        selReg <= regWdata[dmr_pkg::CTRL_SEL_LO +: 2];
      end
    end
  end

  // ==========================================================
  // mode register shadows
  // MR0 test mode and reserved bits are never stored, so they never reach the pins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mr0Reg <= 16'h0000;
    end else if (wrMr0) begin
      mr0Reg <= regWdata[dmr_pkg::MR_W-1:0];
      mr0Reg[dmr_pkg::MR0_TM] <= 1'b0;
      mr0Reg[dmr_pkg::MR_W-1:dmr_pkg::MR0_RFU_LO] <= 3'h0;
    end else if (issue && (selReg == dmr_pkg::SEL_MR0)) begin
      mr0Reg[dmr_pkg::MR0_DLL] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mrxReg <= 16'h0000;
    end else if (regWr && (regAddr == dmr_pkg::OFF_MRX)) begin
      mrxReg <= regWdata[dmr_pkg::MR_W-1:0];
    end
  end

  // ==========================================================
  // pending order and sticky flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pendReg <= 1'b0;
    end else if (goReq && goOk) begin
      pendReg <= 1'b1;
    end else if (issue) begin
      pendReg <= 1'b0;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      refusedReg <= 1'b0;
    end else if ((goReq && !goOk) || (userReq && !userAckReg && userBad)) begin
      refusedReg <= 1'b1;
    end else if (wrStat && regWdata[dmr_pkg::STAT_REFUSED]) begin
      refusedReg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      writtenReg <= 4'h0;
    end else if (issue) begin
      writtenReg[selReg] <= 1'b1;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      dmr_pkg::ST_IDLE: begin
        if (issue) begin
          stateNext = dmr_pkg::ST_MRS;
        end
      end
      dmr_pkg::ST_MRS: begin
        stateNext = dmr_pkg::ST_WAIT;
      end
      dmr_pkg::ST_WAIT: begin
        if (issue) begin
          stateNext = dmr_pkg::ST_MRS;
        end else if (!modRun) begin
          stateNext = dmr_pkg::ST_IDLE;
        end
      end
      default: begin
        stateNext = dmr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stateReg <= dmr_pkg::ST_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  dmr_timer #(
    .W    (dmr_pkg::TIMER_W),
    .LOAD (dmr_pkg::TMRD_LOAD)
  ) uMrd (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (issue),
    .running (mrdRun)
  );

  dmr_timer #(
    .W    (dmr_pkg::TIMER_W),
    .LOAD (dmr_pkg::TMOD_LOAD)
  ) uMod (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (issue),
    .running (modRun)
  );

  // ==========================================================
  // device pins
  always_comb begin
    // whole register image every time, never a partial update
    if (selReg == dmr_pkg::SEL_MR0) begin
      mrsAddr = mr0Reg;
    end else begin
      mrsAddr = mrxReg;
    end
    mrsAddr[dmr_pkg::MR_W-1:dmr_pkg::MR0_RFU_LO] = 3'h0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {ddrCsN, ddrRasN, ddrCasN, ddrWeN} <= dmr_pkg::CMD_DES;
      ddrBa   <= 3'h0;
      ddrAddr <= 16'h0000;
    end else if (issue) begin
      {ddrCsN, ddrRasN, ddrCasN, ddrWeN} <= dmr_pkg::CMD_MRS;
      ddrBa   <= {1'b0, selReg};
      ddrAddr <= mrsAddr;
    end else if (userFire) begin
      {ddrCsN, ddrRasN, ddrCasN, ddrWeN} <= userCmd;
      ddrBa   <= userBa;
      ddrAddr <= userAddr;
    end else begin
      {ddrCsN, ddrRasN, ddrCasN, ddrWeN} <= dmr_pkg::CMD_NOP;
      ddrBa   <= 3'h0;
      ddrAddr <= 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ddrResetN <= 1'b0;
      ddrCke    <= 1'b0;
    end else begin
      ddrResetN <= rstRelReg;
      ddrCke    <= ckeReg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      userAckReg <= 1'b0;
    end else begin
      userAckReg <= userFire || (userReq && !userAckReg && userBad);
    end
  end

  always_comb begin
    userAck = userAckReg;
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_comb begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      dmr_pkg::OFF_CTRL: begin
        rdMux[dmr_pkg::CTRL_SEL_LO +: 2] = selReg;
        rdMux[dmr_pkg::CTRL_CKE]         = ckeReg;
        rdMux[dmr_pkg::CTRL_RST]         = rstRelReg;
      end
      dmr_pkg::OFF_MR0: begin
        rdMux[dmr_pkg::MR_W-1:0] = mr0Reg;
      end
      dmr_pkg::OFF_MRX: begin
        rdMux[dmr_pkg::MR_W-1:0] = mrxReg;
      end
      dmr_pkg::OFF_STAT: begin
        rdMux[dmr_pkg::STAT_BUSY]    = pendReg || (stateReg != dmr_pkg::ST_IDLE);
        rdMux[dmr_pkg::STAT_MRD]     = mrdRun;
        rdMux[dmr_pkg::STAT_MOD]     = modRun;
        rdMux[dmr_pkg::STAT_REFUSED] = refusedReg;
        rdMux[dmr_pkg::STAT_INIT]    = allInit;
        // fixed chop pulls write recovery in by two clocks
        rdMux[dmr_pkg::STAT_BC4FIX]  = (mr0Reg[dmr_pkg::MR0_BL_LO +: 2] == dmr_pkg::BL_FIX4);
        rdMux[dmr_pkg::STAT_WRIT_LO +: dmr_pkg::MR_NUM] = writtenReg;
      end
      default: begin
        rdMux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence mrsOnPins;
    ({ddrCsN, ddrRasN, ddrCasN, ddrWeN} == dmr_pkg::CMD_MRS) && (stateReg == dmr_pkg::ST_MRS);
  endsequence

  sequence mr0OnPins;
    ({ddrCsN, ddrRasN, ddrCasN, ddrWeN} == dmr_pkg::CMD_MRS) && (ddrBa == 3'h0);
  endsequence

  AST_MRS_PINS: assert property (issue |=> mrsOnPins)
    else $error("mrs order did not reach the pins");

  AST_MRD_GAP: assert property (issue |=> !issue [*3])
    else $error("mrs commands closer than tMRD");

  AST_MOD_BLOCK: assert property (issue |=> !userFire [*8])
    else $error("user command inside tMOD");

  AST_NOP_FILL: assert property ($past(modRun) && !$past(issue) |->
      ({ddrCsN, ddrRasN, ddrCasN, ddrWeN} == dmr_pkg::CMD_NOP))
    else $error("non-nop on pins while timers run");

  AST_MR0_RFU: assert property (mr0OnPins |->
      (ddrAddr[dmr_pkg::MR_W-1:dmr_pkg::MR0_RFU_LO] == 3'h0) && !ddrBa[2])
    else $error("reserved mr0 bits driven high");

  AST_TM_OFF: assert property (mr0OnPins |-> !ddrAddr[dmr_pkg::MR0_TM])
    else $error("test mode bit set in mr0");

  AST_IDLE_ONLY: assert property (issue |-> (devIdle && ckeReg) ##1 ddrCke)
    else $error("mrs issued while device not idle");

  AST_DLL_CLEAR: assert property (issue && (selReg == dmr_pkg::SEL_MR0) && !wrMr0
      |=> !mr0Reg[dmr_pkg::MR0_DLL])
    else $error("dll reset bit not cleared after mr0");

  AST_INIT_GATE: assert property (userFire |-> allInit ##1 userAck)
    else $error("user command before all mode registers written");

  AST_WR_REFUSE: assert property (goReq && (stateReg == dmr_pkg::ST_IDLE) && !pendReg
      && (regWdata[dmr_pkg::CTRL_SEL_LO +: 2] == dmr_pkg::SEL_MR0) && !wrCodeOk
      |=> refusedReg && !pendReg)
    else $error("mr0 with short write recovery not refused");

endmodule

/* File: verilog/dmr_timer.sv */
`timescale 1ns/100ps
module dmr_timer #(
  parameter int                             W    = 4,
  parameter logic [W-1:0]                   LOAD = '0
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         start,
  output logic                              running
);

  logic [W-1:0] countReg;

  // ==========================================================
  // down counter, loaded on start
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      countReg <= '0;
    end else if (start) begin
      countReg <= LOAD;
    end else if (countReg != '0) begin
      countReg <= countReg - W'(1);
    end
  end

  always_comb begin
    running = (countReg != '0);
  end

endmodule
